// file: verilog/smas_map.svh
// Constants of the serial memory access link: commands, field lengths, timing.
`ifndef SMAS_MAP_SVH
`define SMAS_MAP_SVH
`define SMAS_CMD_WRITE 8'h02
`define SMAS_CMD_READ 8'h03
`define SMAS_CMD_LAST_BIT 4'h7
`define SMAS_WORD_LAST_BIT 4'hf
`define SMAS_HDR_LAST_BIT 5'h17
`define SMAS_WORD_BITS_LAST 5'h0f
`define SMAS_FIFO_WIDTH 32
`define SMAS_FIFO_DEPTH 8
`define SMAS_MISO_RESET 1'b0
`define SMAS_REF_PERIOD_NS 50
`define SMAS_SCLK_PERIOD_NS 400
`define SMAS_SCLK_DIV (`SMAS_SCLK_PERIOD_NS / `SMAS_REF_PERIOD_NS)
`define SMAS_RESET_SCLK_CYCLES 2
`define SMAS_GAP_TICKS (`SMAS_RESET_SCLK_CYCLES * `SMAS_SCLK_DIV)
`endif

// file: verilog/smas_pkg.sv
// Types shared by both ends of the serial memory access link.
`default_nettype none
package smas_pkg;
	typedef enum logic [2:0] {
		SMAS_IDLE, SMAS_CMD, SMAS_ADDR, SMAS_WDATA, SMAS_CHECK, SMAS_RDATA, SMAS_SKIP
	} smas_phase_e;
	typedef enum logic [1:0] {
		SMAS_M_IDLE, SMAS_M_GAP, SMAS_M_SHIFT, SMAS_M_END
	} smas_mstate_e;
endpackage
`default_nettype wire

// file: verilog/smas_if.sv
// Four-wire serial link between the master and the memory access slave.
`timescale 1ns/1ps
`default_nettype none
interface smas_if;
	logic serial_clk;
	logic serial_select_n;
	logic serial_mosi;
	logic serial_miso;
	modport device (
		input serial_clk,
		input serial_select_n,
		input serial_mosi,
		output serial_miso
	);
	modport master (
		output serial_clk,
		output serial_select_n,
		output serial_mosi,
		input serial_miso
	);
endinterface
`default_nettype wire

// file: verilog/smas_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module smas_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic do_push, do_pop;
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign do_push = in_valid && in_ready;
	assign do_pop = out_valid && out_ready;
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (do_push) begin
			next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
		end
		if (do_pop) begin
			next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
		end
		if (do_push && !do_pop) begin
			next_count = count + (AW+1)'(1);
		end else if (do_pop && !do_push) begin
			next_count = count - (AW+1)'(1);
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end
	// The storage has no reset so that it can map onto plain memory cells.
	always_ff @(posedge ref_clk) begin
		if (do_push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule // smas_fifo
`default_nettype wire

// file: verilog/smas_device.sv
// Serial memory access slave: the device end that serves the 16-bit word space.
`timescale 1ns/1ps
`default_nettype none
`include "smas_map.svh"
// What this block does
// - Master holds select high two clocks first.
// - Select low, then 8-bit command shifts in.
// - A 16-bit start address follows the command.
// - Then zero or more 16-bit data words.
// - Master keeps select low through the transaction.
// - Input line sampled on serial clock rise.
// - Read output changes on serial clock fall.
// - Only the master drives the serial clock.
// - Select high ends frame, drops partial word.
// - Each further 16 clocks moves the next word.
// - Command 02 writes consecutive locations from address.
// - Command 03 reads the addressed location.
// - Read sends check word, then location contents.
// - Check word is command and address high byte.
// - Reads continue over consecutive locations until deselect.
// - Deselected output: low running, high halted, driven.
// - Output is never shared with other slaves.
// - Works whether the processor runs or halts.
module smas_device
	import smas_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	smas_if.device link,
	input wire logic cpu_halted,
	output logic mem_rd_req,
	output logic [15:0] mem_rd_addr,
	input wire logic mem_rd_valid,
	input wire logic [15:0] mem_rd_data,
	output logic mem_wr_valid,
	output logic [15:0] mem_wr_addr,
	output logic [15:0] mem_wr_data,
	input wire logic mem_wr_ready,
	output logic buf_ready
);
	// Index 2 is the clock, 1 the data input, 0 the select.
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic sclk_q;
	logic rise, fall, sel_n_s, mosi_s;
	smas_phase_e phase, next_phase;
	logic [3:0] cnt, next_cnt;
	logic [7:0] cmd, next_cmd;
	logic [15:0] addr, next_addr;
	logic [15:0] in_sr, next_in_sr;
	logic [15:0] out_sr, next_out_sr;
	logic [15:0] rd_buf, next_rd_buf;
	logic [15:0] rd_addr, next_rd_addr;
	logic miso, next_miso;
	logic rd_req, next_rd_req;
	logic push, next_push;
	logic [31:0] push_data, next_push_data;
	logic wr_valid, next_wr_valid;
	logic [15:0] wr_addr, next_wr_addr;
	logic [15:0] wr_data, next_wr_data;
	logic buf_rdy, next_buf_rdy;
	logic f_in_ready, f_out_valid, f_out_ready;
	logic [31:0] f_out_data;

	assign sel_n_s = sync2[0];
	assign mosi_s = sync2[1];
	assign rise = sync2[2] && !sclk_q;
	assign fall = !sync2[2] && sclk_q;
	assign f_out_ready = !wr_valid || mem_wr_ready;

	// Write words wait here so that a slow memory port loses no word until all 8 entries are full.
	smas_fifo #(
		.WIDTH(`SMAS_FIFO_WIDTH),
		.DEPTH(`SMAS_FIFO_DEPTH)
	) u_wr_fifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.in_valid(push),
		.in_ready(f_in_ready),
		.in_data(push_data),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out_data)
	);

	always_comb begin
		logic [15:0] word;
		word = 16'h0000;
		next_phase = phase;
		next_cnt = cnt;
		next_cmd = cmd;
		next_addr = addr;
		next_in_sr = in_sr;
		next_out_sr = out_sr;
		next_rd_buf = rd_buf;
		next_rd_addr = rd_addr;
		next_miso = miso;
		next_rd_req = 1'b0;
		next_push = 1'b0;
		next_push_data = push_data;
		next_buf_rdy = f_in_ready;
		next_wr_valid = wr_valid;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		if (mem_rd_valid) begin
			next_rd_buf = mem_rd_data;
		end
		if (f_out_valid && f_out_ready) begin
			next_wr_valid = 1'b1;
			next_wr_addr = f_out_data[31:16];
			next_wr_data = f_out_data[15:0];
		end else if (mem_wr_ready) begin
			next_wr_valid = 1'b0;
		end
		if (sel_n_s) begin
			// A partial word is dropped and the address stops here.
			next_phase = SMAS_IDLE;
			next_cnt = 4'h0;
			next_miso = cpu_halted;
		end else begin
			if (rise) begin
				next_in_sr = {in_sr[14:0], mosi_s};
				next_cnt = cnt + 4'h1;
				case (phase)
					SMAS_IDLE, SMAS_CMD: begin
						next_phase = SMAS_CMD;
						if (cnt == `SMAS_CMD_LAST_BIT) begin
							next_cmd = {in_sr[6:0], mosi_s};
							next_phase = SMAS_ADDR;
							next_cnt = 4'h0;
						end
					end
					SMAS_ADDR: begin
						if (cnt == `SMAS_WORD_LAST_BIT) begin
							next_addr = {in_sr[14:0], mosi_s};
							if (cmd == `SMAS_CMD_WRITE) begin
								next_phase = SMAS_WDATA;
							end else if (cmd == `SMAS_CMD_READ) begin
								next_phase = SMAS_CHECK;
								next_rd_req = 1'b1;
								next_rd_addr = next_addr;
							end else begin
								next_phase = SMAS_SKIP;
							end
						end
					end
					SMAS_WDATA: begin
						if (cnt == `SMAS_WORD_LAST_BIT) begin
							next_push = 1'b1;
							next_push_data = {addr, in_sr[14:0], mosi_s};
							next_addr = addr + 16'h0001;
						end
					end
					SMAS_CHECK: begin
						if (cnt == `SMAS_WORD_LAST_BIT) begin
							next_phase = SMAS_RDATA;
						end
					end
					SMAS_RDATA: begin
						if (cnt == `SMAS_WORD_LAST_BIT) begin
							next_addr = addr + 16'h0001;
						end
					end
					default: begin
					end
				endcase
			end
			if (fall && (phase == SMAS_CHECK || phase == SMAS_RDATA)) begin
				if (cnt == 4'h0) begin
					if (phase == SMAS_CHECK) begin
						word = {cmd, addr[15:8]};
					end else begin
						word = rd_buf;
						// Fetch the next word now so memory has a whole word time.
						next_rd_req = 1'b1;
						next_rd_addr = addr + 16'h0001;
					end
					next_miso = word[15];
					next_out_sr = {word[14:0], 1'b0};
				end else begin
					next_miso = out_sr[15];
					next_out_sr = {out_sr[14:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 3'h1;
			sync2 <= 3'h1;
			sclk_q <= 1'b0;
			phase <= SMAS_IDLE;
			cnt <= 4'h0;
			cmd <= 8'h00;
			addr <= 16'h0000;
			in_sr <= 16'h0000;
			out_sr <= 16'h0000;
			rd_buf <= 16'h0000;
			rd_addr <= 16'h0000;
			miso <= `SMAS_MISO_RESET;
			rd_req <= 1'b0;
			push <= 1'b0;
			push_data <= 32'h00000000;
			wr_valid <= 1'b0;
			wr_addr <= 16'h0000;
			wr_data <= 16'h0000;
			buf_rdy <= 1'b0;
		end else begin
			sync1 <= {link.serial_clk, link.serial_mosi, link.serial_select_n};
			sync2 <= sync1;
			sclk_q <= sync2[2];
			phase <= next_phase;
			cnt <= next_cnt;
			cmd <= next_cmd;
			addr <= next_addr;
			in_sr <= next_in_sr;
			out_sr <= next_out_sr;
			rd_buf <= next_rd_buf;
			rd_addr <= next_rd_addr;
			miso <= next_miso;
			rd_req <= next_rd_req;
			push <= next_push;
			push_data <= next_push_data;
			wr_valid <= next_wr_valid;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
			buf_rdy <= next_buf_rdy;
		end
	end

	// The output is always driven, so it cannot be wired in parallel.
	assign link.serial_miso = miso;
	assign mem_rd_req = rd_req;
	assign mem_rd_addr = rd_addr;
	assign mem_wr_valid = wr_valid;
	assign mem_wr_addr = wr_addr;
	assign mem_wr_data = wr_data;
	assign buf_ready = buf_rdy;
endmodule // smas_device
`default_nettype wire

// file: verilog/smas_master.sv
// Serial memory access master: the far end that clocks the link.
`timescale 1ns/1ps
`default_nettype none
`include "smas_map.svh"
module smas_master
	import smas_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	smas_if.master link,
	input wire logic start,
	input wire logic [7:0] start_cmd,
	input wire logic [15:0] start_addr,
	input wire logic [7:0] start_words,
	input wire logic [15:0] tx_data,
	output logic tx_take,
	output logic rx_valid,
	output logic [15:0] rx_data,
	output logic [15:0] check_data,
	output logic busy
);
	smas_mstate_e state, next_state;
	logic [4:0] tick, next_tick;
	logic [4:0] bits, next_bits;
	logic hdr, next_hdr;
	logic rd, next_rd;
	logic chk, next_chk;
	logic [8:0] left, next_left;
	logic [23:0] out_sr, next_out_sr;
	logic [15:0] in_sr, next_in_sr;
	logic sclk, next_sclk, sel_n, next_sel_n, mosi, next_mosi;
	logic take, next_take, rxv, next_rxv;
	logic [15:0] rxd, next_rxd, chkd, next_chkd;
	logic miso_1, miso_2;
	logic bsy, next_bsy;

	always_comb begin
		next_state = state;
		next_tick = tick + 5'h01;
		next_bits = bits;
		next_hdr = hdr;
		next_rd = rd;
		next_chk = chk;
		next_left = left;
		next_out_sr = out_sr;
		next_in_sr = in_sr;
		next_sclk = sclk;
		next_sel_n = sel_n;
		next_mosi = mosi;
		next_take = 1'b0;
		next_rxv = 1'b0;
		next_rxd = rxd;
		next_chkd = chkd;
		case (state)
			SMAS_M_IDLE: begin
				next_tick = 5'h00;
				if (start) begin
					next_state = SMAS_M_GAP;
					next_out_sr = {start_cmd, start_addr};
					next_rd = (start_cmd == `SMAS_CMD_READ);
					next_chk = (start_cmd == `SMAS_CMD_READ);
					next_left = {1'b0, start_words} + ((start_cmd == `SMAS_CMD_READ) ? 9'h001 : 9'h000);
					next_hdr = 1'b1;
					next_bits = 5'h00;
				end
			end
			SMAS_M_GAP: begin
				if (tick == 5'(`SMAS_GAP_TICKS - 1)) begin
					next_state = SMAS_M_SHIFT;
					next_sel_n = 1'b0;
					next_tick = 5'h00;
				end
			end
			SMAS_M_SHIFT: begin
				if (tick == 5'h00) begin
					next_sclk = 1'b0;
					next_mosi = out_sr[23];
					next_out_sr = {out_sr[22:0], 1'b0};
				end
				if (tick == 5'(`SMAS_SCLK_DIV / 2)) begin
					next_sclk = 1'b1;
				end
				if (tick == 5'(`SMAS_SCLK_DIV - 1)) begin
					// Sampling late in the high half leaves room for both synchronisers.
					next_tick = 5'h00;
					next_in_sr = {in_sr[14:0], miso_2};
					next_bits = bits + 5'h01;
					if (hdr && bits == `SMAS_HDR_LAST_BIT) begin
						next_hdr = 1'b0;
						next_bits = 5'h00;
						if (!rd && left != 9'h000) begin
							next_out_sr = {tx_data, 8'h00};
							next_take = 1'b1;
						end
						if (left == 9'h000) begin
							next_state = SMAS_M_END;
						end
					end else if (!hdr && bits == `SMAS_WORD_BITS_LAST) begin
						next_bits = 5'h00;
						next_left = left - 9'h001;
						if (chk) begin
							next_chk = 1'b0;
							next_chkd = {in_sr[14:0], miso_2};
						end else if (rd) begin
							next_rxv = 1'b1;
							next_rxd = {in_sr[14:0], miso_2};
						end
						if (!rd && left > 9'h001) begin
							next_out_sr = {tx_data, 8'h00};
							next_take = 1'b1;
						end
						if (left == 9'h001) begin
							next_state = SMAS_M_END;
						end
					end
				end
			end
			SMAS_M_END: begin
				if (tick == 5'h00) begin
					next_sclk = 1'b0;
				end
				if (tick == 5'(`SMAS_SCLK_DIV - 1)) begin
					next_sel_n = 1'b1;
					next_state = SMAS_M_IDLE;
				end
			end
			default: begin
				next_state = SMAS_M_IDLE;
			end
		endcase
		next_bsy = (next_state != SMAS_M_IDLE);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= SMAS_M_IDLE;
			tick <= 5'h00;
			bits <= 5'h00;
			hdr <= 1'b0;
			rd <= 1'b0;
			chk <= 1'b0;
			left <= 9'h000;
			out_sr <= 24'h000000;
			in_sr <= 16'h0000;
			sclk <= 1'b0;
			sel_n <= 1'b1;
			mosi <= 1'b0;
			take <= 1'b0;
			rxv <= 1'b0;
			rxd <= 16'h0000;
			chkd <= 16'h0000;
			miso_1 <= 1'b0;
			miso_2 <= 1'b0;
			bsy <= 1'b0;
		end else begin
			state <= next_state;
			tick <= next_tick;
			bits <= next_bits;
			hdr <= next_hdr;
			rd <= next_rd;
			chk <= next_chk;
			left <= next_left;
			out_sr <= next_out_sr;
			in_sr <= next_in_sr;
			sclk <= next_sclk;
			sel_n <= next_sel_n;
			mosi <= next_mosi;
			take <= next_take;
			rxv <= next_rxv;
			rxd <= next_rxd;
			chkd <= next_chkd;
			miso_1 <= link.serial_miso;
			miso_2 <= miso_1;
			bsy <= next_bsy;
		end
	end

	assign link.serial_clk = sclk;
	assign link.serial_select_n = sel_n;
	assign link.serial_mosi = mosi;
	assign tx_take = take;
	assign rx_valid = rxv;
	assign rx_data = rxd;
	assign check_data = chkd;
	assign busy = bsy;
endmodule // smas_master
`default_nettype wire

// file: verif/smas_monitor.sv
// Concurrent checks on the four wires between the two link ends.
`timescale 1ns/1ps
`default_nettype none
module smas_monitor (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic serial_clk,
	input wire logic serial_select_n,
	input wire logic serial_mosi,
	input wire logic serial_miso,
	input wire logic cpu_halted
);
	logic [4:0] gap;
	logic [4:0] next_gap;
	logic [11:0] bits;
	logic [11:0] next_bits;
	logic clk_q;
	logic next_clk_q;
	// The gap count saturates so that a long idle never wraps back below the minimum.
	always_comb begin
		next_clk_q = serial_clk;
		next_gap = serial_select_n ? gap + {4'h0, ~&gap} : 5'h00;
		next_bits = serial_select_n ? 12'h000 : bits + {11'h000, serial_clk & ~clk_q};
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap <= 5'h00;
			bits <= 12'h000;
			clk_q <= 1'b0;
		end else begin
			gap <= next_gap;
			bits <= next_bits;
			clk_q <= next_clk_q;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_gap; $fell(serial_select_n) |-> gap >= 5'h10; endproperty
	property p_first; $fell(serial_select_n) |-> !serial_clk [*4]; endproperty
	property p_clk_sel; serial_clk |-> !serial_select_n; endproperty
	property p_mosi; $rose(serial_clk) |-> $stable(serial_mosi) ##1 $stable(serial_mosi); endproperty
	property p_miso_fall; !serial_select_n && $changed(serial_miso) |-> !serial_clk; endproperty
	property p_miso_hold; $rose(serial_clk) |=> $stable(serial_miso) [*3]; endproperty
	property p_idle;
		// Reset drives the output low whatever the halt state, so the first edges are skipped.
		serial_select_n && $past(serial_select_n, 4) && $past(rst_n, 2) &&
			$past(cpu_halted, 4) == cpu_halted
			|-> serial_miso == cpu_halted;
	endproperty
	property p_frame; $rose(serial_select_n) |-> bits >= 12'h018 && bits[3:0] == 4'h8; endproperty
	a_gap: assert property (p_gap)
		else $error("select went low after too short a high interval");
	a_first: assert property (p_first)
		else $error("serial clock moved right after select fell");
	a_clk_sel: assert property (p_clk_sel)
		else $error("serial clock high while deselected");
	a_mosi: assert property (p_mosi)
		else $error("input line moved around the sampling rise");
	a_miso_fall: assert property (p_miso_fall)
		else $error("output line changed while serial clock high");
	a_miso_hold: assert property (p_miso_hold)
		else $error("output line not held after the rise");
	a_idle: assert property (p_idle)
		else $error("deselected output level does not follow the halt state");
	a_frame: assert property (p_frame)
		else $error("frame length is not header plus whole words");
	c_frame: cover property ($fell(serial_select_n));
	c_long: cover property ($rose(serial_select_n) && bits > 12'h028);
	c_halt: cover property (serial_select_n && cpu_halted && serial_miso);
endmodule // smas_monitor
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench joining the master and device ends of the serial link.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct {logic [7:0] cmd; logic [15:0] addr; logic [7:0] n; logic halt;} smas_row_s;
	logic ref_clk = 0, rst_n = 0, m_rst_n = 0, cpu_halted = 0, start = 0;
	logic [7:0] start_cmd = 0, start_words = 0;
	logic [15:0] start_addr = 0, tx_data = 0, rd_data = 0;
	logic rd_valid = 0, wr_ready = 1;
	logic mem_rd_req, mem_wr_valid, buf_ready, tx_take, rx_valid, busy;
	logic [15:0] mem_rd_addr, mem_wr_addr, mem_wr_data, rx_data, check_data;
	logic [15:0] mem [256];
	logic [15:0] expm [256];
	logic [15:0] rxq [$];
	int fails = 0, check_count = 0, widx = 0;
	smas_row_s rows [8] = '{
		'{8'h02, 16'h0010, 8'h01, 1'b0}, '{8'h02, 16'h0020, 8'h03, 1'b1},
		'{8'h03, 16'h0010, 8'h01, 1'b0}, '{8'h03, 16'h121f, 8'h03, 1'b1},
		'{8'h02, 16'h00ff, 8'h02, 1'b0}, '{8'h03, 16'h4321, 8'h00, 1'b0},
		'{8'h07, 16'h0040, 8'h01, 1'b0}, '{8'h02, 16'h0050, 8'h00, 1'b1}};
	always #25 ref_clk = ~ref_clk;
	smas_if link_if ();
	smas_device smas_device_inst (.ref_clk, .rst_n, .link(link_if.device), .cpu_halted,
		.mem_rd_req, .mem_rd_addr, .mem_rd_valid(rd_valid), .mem_rd_data(rd_data),
		.mem_wr_valid, .mem_wr_addr, .mem_wr_data, .mem_wr_ready(wr_ready), .buf_ready);
	smas_master smas_master_inst (.ref_clk, .rst_n(m_rst_n), .link(link_if.master), .start,
		.start_cmd, .start_addr, .start_words, .tx_data, .tx_take, .rx_valid, .rx_data,
		.check_data, .busy);
	smas_monitor smas_monitor_inst (.ref_clk, .rst_n(rst_n & m_rst_n),
		.serial_clk(link_if.serial_clk), .serial_select_n(link_if.serial_select_n),
		.serial_mosi(link_if.serial_mosi), .serial_miso(link_if.serial_miso), .cpu_halted);
	function automatic logic [15:0] wdat(input logic [15:0] a, input int k);
		return {a[7:0] + 8'(k), 8'hc3};
	endfunction
	// Memory side of the device: reads answer half a cycle after the request.
	always @(negedge ref_clk) begin
		rd_valid <= mem_rd_req;
		rd_data <= mem[mem_rd_addr[7:0]];
		if (tx_take) begin
			widx <= widx + 1;
			tx_data <= wdat(start_addr, widx + 1);
		end
	end
	always @(posedge ref_clk) begin
		if (mem_wr_valid && wr_ready) mem[mem_wr_addr[7:0]] <= mem_wr_data;
		if (rx_valid) rxq.push_back(rx_data);
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask
	task automatic tally_and_finish;
		if (fails == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic kick(input smas_row_s r);
		@(negedge ref_clk);
		cpu_halted = r.halt;
		start_cmd = r.cmd;
		start_addr = r.addr;
		start_words = r.n;
		widx = 0;
		tx_data = wdat(r.addr, 0);
		rxq = {};
		start = 1;
		@(negedge ref_clk);
		start = 0;
	endtask
	// A stalled memory keeps valid up, so the drain wait is bounded rather than exact.
	task automatic drain;
		for (int t = 0; t < 200 && mem_wr_valid !== 1'b0; t++) @(negedge ref_clk);
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic xfer(input smas_row_s r);
		kick(r);
		for (int t = 0; t < 9000 && busy !== 1'b0; t++) @(negedge ref_clk);
		if (busy !== 1'b0) fails++;
		drain;
	endtask
	task automatic run(input smas_row_s r);
		logic [7:0] i;
		xfer(r);
		chk(16'(link_if.serial_miso), 16'(r.halt));
		chk(16'(rxq.size()), r.cmd == 8'h03 ? 16'(r.n) : 16'h0);
		if (r.cmd == 8'h03) chk(check_data, {r.cmd, r.addr[15:8]});
		for (int k = 0; k < r.n; k++) begin
			i = r.addr[7:0] + 8'(k);
			if (r.cmd == 8'h02) expm[i] = wdat(r.addr, k);
			chk(r.cmd == 8'h03 ? rxq[k] : mem[i], expm[i]);
		end
	endtask
	initial begin
		int n;
		for (int i = 0; i < 256; i++) begin
			mem[i] = {~8'(i), 8'(i)};
			expm[i] = mem[i];
		end
		repeat (6) @(negedge ref_clk);
		rst_n = 1;
		m_rst_n = 1;
		foreach (rows[r]) run(rows[r]);
		// The 8-deep write buffer fills while the memory stalls.
		wr_ready = 0;
		xfer('{8'h02, 16'h0080, 8'h0a, 1'b0});
		chk(16'(buf_ready), 16'h0);
		wr_ready = 1;
		drain;
		chk(16'(buf_ready), 16'h1);
		for (int k = 0; k < 8; k++) chk(mem[8'h80 + k], wdat(16'h0080, k));
		// The master is reset in mid-word so select rises with a partial word in flight.
		n = 0;
		kick('{8'h02, 16'h0090, 8'h02, 1'b0});
		for (int t = 0; n < 2 && t < 2000; t++) begin
			@(negedge ref_clk);
			n += int'(tx_take);
		end
		if (n < 2) fails++;
		repeat (64) @(negedge ref_clk);
		m_rst_n = 0;
		@(negedge ref_clk);
		m_rst_n = 1;
		drain;
		chk(mem[8'h90], wdat(16'h0090, 0));
		chk(mem[8'h91], expm[8'h91]);
		expm[8'h90] = wdat(16'h0090, 0);
		run(rows[2]);
		cpu_halted = 0;
		kick(rows[3]);
		repeat (100) @(negedge ref_clk);
		rst_n = 0;
		m_rst_n = 0;
		@(negedge ref_clk);
		chk(16'({link_if.serial_miso, link_if.serial_select_n, busy, buf_ready,
			mem_wr_valid, mem_rd_req}), 16'h0010);
		rst_n = 1;
		m_rst_n = 1;
		repeat (2) @(negedge ref_clk);
		chk(16'(buf_ready), 16'h1);
		run(rows[3]);
		tally_and_finish;
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		fails++;
		tally_and_finish;
	end
endmodule // testbench
`default_nettype wire
